// [inc/pmc_pkg.sv]
// package for the link function's phy control and misc configuration regs
// assumes a 32-bit configuration access port with byte enables
package pmc_pkg;

    // -----------------------------------------------------------------
    // register offsets (configuration space byte addresses)
    // -----------------------------------------------------------------
    localparam logic [7:0] PMC_PHY_CONTROL_OFFSET = 8'hEC;
    localparam logic [7:0] PMC_MISC_CONFIGURATION_OFFSET = 8'hF0;

    // -----------------------------------------------------------------
    // phy control fields
    // -----------------------------------------------------------------
    localparam int PMC_ROUTE_BIT = 7;
    localparam int PMC_COMPLY_BIT = 3;
    localparam logic [7:0] PMC_PHY_WR_MASK = 8'h9F;
    localparam logic [7:0] PMC_PHY_RESET = 8'h08;
    localparam logic [7:0] PMC_EEPROM_PHY_BYTE = 8'h38;

    // -----------------------------------------------------------------
    // misc configuration fields
    // -----------------------------------------------------------------
    localparam int PMC_COLD_WAKE_BIT = 15;
    localparam int PMC_CONFORM_BIT = 11;
    localparam int PMC_IGNORE_BIT = 10;
    localparam logic [31:0] PMC_MISC_RESET = 32'h0000_0800;
    localparam int PMC_VENDOR_WAKE_BIT = 26;
    localparam logic [7:0] PMC_VENDOR_ID_OFFSET = 8'h40;

    // -----------------------------------------------------------------
    // bus carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } pmc_cfg_req_s;

    typedef struct packed {
        logic load;
        logic [7:0] data;
    } pmc_eeprom_load_s;

endpackage

// [logic/pmc_regs.sv]
// phy control and misc configuration registers of the link function
// assumes single-cycle config accesses on clk_sys and a loader that
// presents eeprom byte 38h for one cycle when it is present
`timescale 1ns/1ps
module pmc_regs
    import pmc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic pcie_reset_n,
    input wire logic global_reset_in_n,
    input wire logic power_on_reset,
    input wire pmc_cfg_req_s cfg_req,
    output logic [31:0] cfg_rdata,
    output logic cfg_ack,
    input wire pmc_eeprom_load_s eeprom_load,
    input wire logic cable_not_active,
    output logic cable_indication_out,
    input wire logic [31:0] irq_unmasked,
    input wire logic master_irq_enable,
    output logic wake_request,
    output logic wake_ignores_master_irq_enable_vid
);

    // -----------------------------------------------------------------
    // reset combining
    // -----------------------------------------------------------------
    // pins are foreign: each passes a three-flop filter, and a change
    // only counts once stages two and three agree, in both directions
    logic [2:0] pin_reset_raw;
    logic [2:0] pin_reset_seen;
    logic soft_reset;

    // all three are turned active high before filtering, so one filter
    // shape serves every source
    always_comb begin
        pin_reset_raw[0] = ~pcie_reset_n;
        pin_reset_raw[1] = ~global_reset_in_n;
        pin_reset_raw[2] = power_on_reset;
    end

    pmc_pin_filter i_perst_filter (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin_raw(pin_reset_raw[0]),
        .pin_level(pin_reset_seen[0])
    );

    pmc_pin_filter i_global_reset_in_filter (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin_raw(pin_reset_raw[1]),
        .pin_level(pin_reset_seen[1])
    );

    pmc_pin_filter i_por_filter (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin_raw(pin_reset_raw[2]),
        .pin_level(pin_reset_seen[2])
    );

    // any of the three events returns the writable bits to default and
    // keeps them there for as long as its filtered level stays active
    assign soft_reset = |pin_reset_seen;

    // -----------------------------------------------------------------
    // access decode
    // -----------------------------------------------------------------
    // a lane must be enabled for its field to move; the phy byte sits in
    // lane 0 and the ignore bit in lane 1, every other lane is fixed
    logic phy_write_hit;
    logic misc_write_hit;
    logic phy_read_hit;
    logic misc_read_hit;

    always_comb begin
        phy_write_hit = cfg_req.wr && cfg_req.be[0]
            && (cfg_req.addr == PMC_PHY_CONTROL_OFFSET);
        misc_write_hit = cfg_req.wr && cfg_req.be[1]
            && (cfg_req.addr == PMC_MISC_CONFIGURATION_OFFSET);
        phy_read_hit = cfg_req.rd
            && (cfg_req.addr == PMC_PHY_CONTROL_OFFSET);
        misc_read_hit = cfg_req.rd
            && (cfg_req.addr == PMC_MISC_CONFIGURATION_OFFSET);
    end

    // -----------------------------------------------------------------
    // eeprom image
    // -----------------------------------------------------------------
    // only the writable phy bits take the byte; the loader is trusted
    // for bits 3 and 1, so a bad image shows up on the next read rather
    // than being silently patched here
    logic [7:0] eeprom_phy_image;

    always_comb begin
        eeprom_phy_image = eeprom_load.data & PMC_PHY_WR_MASK;
    end

    // -----------------------------------------------------------------
    // register state
    // -----------------------------------------------------------------
    logic [7:0] phy_control;
    logic wake_ignores_master_irq_enable;
    logic [7:0] next_phy_control;
    logic next_wake_ignores;
    logic [7:0] phy_wdata;

    always_comb begin
        next_phy_control = phy_control;
        next_wake_ignores = wake_ignores_master_irq_enable;
        // only the writable mask lands, read-only bits stay zero
        phy_wdata = (cfg_req.wdata[7:0] & PMC_PHY_WR_MASK)
            | (phy_control & ~PMC_PHY_WR_MASK);
        if (soft_reset) begin
            next_phy_control = PMC_PHY_RESET;
            next_wake_ignores = 1'b0;
        end else begin
            // the loader is trusted to supply bit 3 set and bit 1 clear
            if (eeprom_load.load) begin
                next_phy_control = eeprom_phy_image;
            end
            // a config write in the same cycle wins over the loader
            if (phy_write_hit) begin
                next_phy_control = phy_wdata;
            end
            if (misc_write_hit) begin
                // bits 15..11 are fixed, only the ignore bit is kept
                next_wake_ignores = cfg_req.wdata[PMC_IGNORE_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            phy_control <= PMC_PHY_RESET;
            wake_ignores_master_irq_enable <= 1'b0;
        end else begin
            phy_control <= next_phy_control;
            wake_ignores_master_irq_enable <= next_wake_ignores;
        end
    end

    // -----------------------------------------------------------------
    // read path
    // -----------------------------------------------------------------
    logic [31:0] next_rdata;
    logic [31:0] misc_view;
    logic [31:0] phy_view;
    logic next_ack;

    // words are built field by field so the fixed bits stay visible
    always_comb begin
        phy_view = 32'h0000_0000;
        phy_view[PMC_ROUTE_BIT] = phy_control[PMC_ROUTE_BIT];
        phy_view[6:5] = 2'b00;
        phy_view[4] = phy_control[4];
        phy_view[PMC_COMPLY_BIT] = phy_control[PMC_COMPLY_BIT];
        phy_view[2:0] = phy_control[2:0];
    end

    always_comb begin
        misc_view = PMC_MISC_RESET;
        misc_view[PMC_COLD_WAKE_BIT] = 1'b0;
        misc_view[PMC_CONFORM_BIT] = 1'b1;
        misc_view[PMC_IGNORE_BIT] = wake_ignores_master_irq_enable;
    end

    // unmapped reads return zero but are still acknowledged, so a probe
    // of an empty slot never stalls the requester
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_ack = cfg_req.rd | cfg_req.wr;
        if (phy_read_hit) begin
            next_rdata = phy_view;
        end else if (misc_read_hit) begin
            next_rdata = misc_view;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cfg_rdata <= 32'h0000_0000;
            cfg_ack <= 1'b0;
        end else begin
            cfg_rdata <= next_rdata;
            cfg_ack <= next_ack;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    // the terminal stays low while routing is off, so the pin never
    // floats into a false cable-not-active reading
    logic next_cable_out;

    always_comb begin
        next_cable_out = phy_control[PMC_ROUTE_BIT]
            & cable_not_active;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cable_indication_out <= 1'b0;
        end else begin
            cable_indication_out <= next_cable_out;
        end
    end

    // -----------------------------------------------------------------
    // wake request
    // -----------------------------------------------------------------
    // master enable gates wake only while the ignore bit is clear; with
    // it set any unmasked source is enough
    logic next_wake;

    always_comb begin
        next_wake = (|irq_unmasked) &
            (master_irq_enable | wake_ignores_master_irq_enable);
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= next_wake;
        end
    end

    // -----------------------------------------------------------------
    // vendor id feed
    // -----------------------------------------------------------------

    // feeds bit 26 of the vendor id register at link offset 40h
    assign wake_ignores_master_irq_enable_vid =
        wake_ignores_master_irq_enable;

endmodule

// -----------------------------------------------------------------
// pin filter
// -----------------------------------------------------------------
// three flops on a level from outside clk_sys; the filtered level only
// moves when the last two stages agree, so a one-cycle glitch that
// slips through the first flop never reaches the registers
module pmc_pin_filter
    import pmc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic pin_raw,
    output logic pin_level
);

    logic [2:0] sync_stage;
    logic [2:0] next_sync_stage;
    logic next_pin_level;

    always_comb begin
        next_sync_stage = {sync_stage[1:0], pin_raw};
        next_pin_level = pin_level;
        if (sync_stage[1] == sync_stage[2]) begin
            next_pin_level = sync_stage[2];
        end
    end

    // the filtered level starts inactive; a pin held active through the
    // async reset still takes effect a few edges after its release
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sync_stage <= 3'h0;
            pin_level <= 1'b0;
        end else begin
            sync_stage <= next_sync_stage;
            pin_level <= next_pin_level;
        end
    end

endmodule

// [test/pmc_regs_chk.sv]
// concurrent checks on the port of the phy control and misc config block
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/1ps
module pmc_chk
    import pmc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire pmc_cfg_req_s cfg_req,
    input wire logic [31:0] cfg_rdata,
    input wire logic cable_not_active,
    input wire logic cable_indication_out,
    input wire logic [31:0] irq_unmasked,
    input wire logic master_irq_enable,
    input wire logic wake_request,
    input wire logic wake_ignores_master_irq_enable_vid
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    wire rd_phy = cfg_req.rd && cfg_req.addr == PMC_PHY_CONTROL_OFFSET;
    wire rd_msc = cfg_req.rd && cfg_req.addr == PMC_MISC_CONFIGURATION_OFFSET;
    wire ign = wake_ignores_master_irq_enable_vid;
    property p_phy_hi; rd_phy |=> cfg_rdata[31:8] == 24'h0; endproperty
    a_phy_hi: assert property (p_phy_hi) else $error("phy high");
    property p_phy_ro; rd_phy |=> cfg_rdata[6:5] == 2'h0; endproperty
    a_phy_ro: assert property (p_phy_ro) else $error("phy 6..5");
    property p_msc_hi; rd_msc |=> cfg_rdata[31:16] == 16'h0; endproperty
    a_msc_hi: assert property (p_msc_hi) else $error("misc high");
    property p_cold; rd_msc |=> cfg_rdata[15:12] == 4'h0; endproperty
    a_cold: assert property (p_cold) else $error("cold");
    property p_conf; rd_msc |=> cfg_rdata[11]; endproperty
    a_conf: assert property (p_conf) else $error("conform");
    property p_vid; rd_msc |=> cfg_rdata[10] == ign; endproperty
    a_vid: assert property (p_vid) else $error("vendor bit");
    property p_route;
        cable_indication_out |-> $past(cable_not_active);
    endproperty
    a_route: assert property (p_route) else $error("route");
    // the first edge after reset still sees inputs from inside reset
    property p_wake;
        !$past(reset) |-> wake_request ==
            $past(|irq_unmasked & (master_irq_enable | ign));
    endproperty
    a_wake: assert property (p_wake) else $error("wake");
    c_route: cover property (cable_indication_out);
    c_wake: cover property (wake_request && !master_irq_enable);
    c_vid: cover property (rd_msc ##1 cfg_rdata[10]);
endmodule
bind pmc_regs pmc_chk i_chk (.*);

// [test/testbench.sv]
// self-checking bench for the phy control and misc configuration registers
// assumes the checker binds itself to the design instance
`timescale 1ns/1ps
module testbench
    import pmc_pkg::*;
;
    logic clk_sys = 1'b0, reset = 1'b1, cable_not_active = 1'b1, vid, cfg_ack;
    logic pcie_reset_n = 1'b1, global_reset_in_n = 1'b1, power_on_reset = 1'b0;
    logic master_irq_enable = 1'b0, cable_indication_out, wake_request;
    logic [31:0] irq_unmasked = 32'h100, cfg_rdata;
    logic [2:0] pins [3] = '{3'b010, 3'b100, 3'b111};
    pmc_cfg_req_s cfg_req = '0;
    pmc_eeprom_load_s eeprom_load = '0;
    int num_errors = 0, num_checks = 0;
    always #4 clk_sys = ~clk_sys;
    pmc_regs i_dut (.*, .wake_ignores_master_irq_enable_vid(vid));
    task automatic tick(int n); repeat (n) @(negedge clk_sys); endtask
    task automatic chk(logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h %h", $time, got, exp);
        end
    endtask
    // d is write data on a write and the expected word on a read
    task automatic acc(logic rd, logic [7:0] a, logic [3:0] be, logic [31:0] d);
        tick(1);
        cfg_req = '{rd, !rd, a, be, d};
        tick(1);
        cfg_req = '0;
        chk(32'(cfg_ack), 32'h1);
        if (rd) chk(cfg_rdata, d);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk_sys);
        num_errors++;
        $display("wrong value at %0t: timeout", $time);
        wrap_up();
    end
    initial begin
        tick(12);
        reset = 1'b0;
        acc(1, 8'hEC, 4'h0, 32'h8);
        acc(0, 8'hEC, 4'hF, '1);
        acc(1, 8'hEC, 4'h0, 32'h9F);
        acc(0, 8'hF0, 4'hF, '1);
        acc(1, 8'hF0, 4'h0, 32'hC00);
        acc(1, 8'h00, 4'h0, 32'h0);
        chk(32'(wake_request), 32'h1);
        chk(32'(vid), 32'h1);
        $display("register test done");
        eeprom_load = '{1'b1, 8'hD8};
        tick(1);
        eeprom_load = '0;
        acc(1, 8'hEC, 4'h0, 32'h98);
        chk(32'(cable_indication_out), 32'h1);
        $display("route test done");
        pcie_reset_n = 1'b0;
        tick(1);
        pcie_reset_n = 1'b1;
        tick(5);
        acc(1, 8'hEC, 4'h0, 32'h98);
        $display("glitch test done");
        for (int i = 0; i < 3; i++) begin
            acc(0, 8'hEC, 4'h1, 32'h80);
            {pcie_reset_n, global_reset_in_n, power_on_reset} = pins[i];
            tick(6);
            {pcie_reset_n, global_reset_in_n, power_on_reset} = 3'b110;
            tick(6);
            acc(1, 8'hEC, 4'h0, 32'h8);
        end
        chk(32'(wake_request), 32'h0);
        chk(32'(vid), 32'h0);
        chk(32'(cable_indication_out), 32'h0);
        $display("reset test done");
        wrap_up();
    end
endmodule
